// ---- rtl/vpit_top.sv ----
/*
 Vectored priority interrupt table: levels, winner, fetch address.
 Assumes sources and core on i_clk; external request arrives from a pin.
*/
// How it works
// [R1] Level 3 requests served before 2, 2 before 1, 1 before 0.
// [R2] Same level: smallest vector number wins.
// [R3] Fetch address is vector base plus each vector's fixed offset.
// [R4] Vectors 2 to 5 are core exceptions fixed at level 3.
// [R5] Debug sources on vectors 6,7,9,10,11 take levels 1 to 3.
// [R6] External request 17, voltage detect 20, clock 21 take levels 0-2.
// [R7] Flash sources on vectors 22, 23, 24 take levels 0-2.
// [R8] CAN sources on vectors 26 to 29 take levels 0-2.
// [R9] Ports C, B, A on vectors 33, 34, 35 take levels 0-2.
// [R10] SPI vectors 38-41 and serial unit 1 vectors 42-43 take 0-2.
// [R11] Software puts jumps in slots 0 and 1, calls elsewhere.
// [R12] After reset fetch boot address; after watchdog reset the next entry, two words on.
// [R13] Each entry is two words; vector n at base plus 2n.
// [R14] Base 0200 makes slots 0 and 1 the reset addresses.
// [R15] Only pending enabled requests; present only at or above core mask.
// [R16] Software interrupts 2,1,0 fixed at levels 2,1,0 on 14,15,16.
`timescale 1ns/10ps
`include "vpit_defs.svh"

module vpit_top (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   input  wire vpit_pkg::vpit_src_t     i_src,
   input  wire logic                    i_ext_request_a_n,
   input  wire logic                    i_ext_edge_mode,
   input  wire logic                    i_wdog_reset_cause,
   input  wire logic [`VPIT_BASE_W-1:0] i_vector_base,
   input  wire vpit_pkg::vpit_core_t    i_core,
   output vpit_pkg::vpit_grant_t        o_grant,
   output logic                         o_overlay,
   output logic                         o_ext_pending
);

   // ----------------------------------------
   // Source classes
   // ----------------------------------------
   function automatic vpit_pkg::vpit_class_t vec_class(
      input logic [`VPIT_VEC_W-1:0] v
   );
      case (v)
         // [R4] Fixed level 3 exceptions
         `VPIT_V_ILLEGAL:   vec_class = vpit_pkg::VPIT_CL_FIX3;
         `VPIT_V_SWI3:      vec_class = vpit_pkg::VPIT_CL_FIX3;
         `VPIT_V_HWSTACK:   vec_class = vpit_pkg::VPIT_CL_FIX3;
         `VPIT_V_MISALIGN:  vec_class = vpit_pkg::VPIT_CL_FIX3;
         // [R5] Debug port sources
         `VPIT_V_DBG_STEP:  vec_class = vpit_pkg::VPIT_CL_DBG;
         `VPIT_V_DBG_BKPT0: vec_class = vpit_pkg::VPIT_CL_DBG;
         `VPIT_V_DBG_TRACE: vec_class = vpit_pkg::VPIT_CL_DBG;
         `VPIT_V_DBG_TXE:   vec_class = vpit_pkg::VPIT_CL_DBG;
         `VPIT_V_DBG_RXF:   vec_class = vpit_pkg::VPIT_CL_DBG;
         // [R16] Fixed software levels
         `VPIT_V_SWI2:      vec_class = vpit_pkg::VPIT_CL_FIX2;
         `VPIT_V_SWI1:      vec_class = vpit_pkg::VPIT_CL_FIX1;
         `VPIT_V_SWI0:      vec_class = vpit_pkg::VPIT_CL_FIX0;
         // [R6] Pin, voltage and clock sources
         `VPIT_V_EXT_A:     vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_LVD:       vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_CLKGEN:    vec_class = vpit_pkg::VPIT_CL_PER;
         // [R7] Flash sources
         `VPIT_V_FL_ACCERR: vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_FL_CCIF:   vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_FL_CBEIF:  vec_class = vpit_pkg::VPIT_CL_PER;
         // [R8] CAN sources
         `VPIT_V_CAN_BOFF:  vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_CAN_ERR:   vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_CAN_WAKE:  vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_CAN_MB:    vec_class = vpit_pkg::VPIT_CL_PER;
         // [R9] Port requests
         `VPIT_V_PORT_C:    vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_PORT_B:    vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_PORT_A:    vec_class = vpit_pkg::VPIT_CL_PER;
         // [R10] Serial peripheral sources
         `VPIT_V_SPI_UNIT_1_RXF:  vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_SPI_UNIT_1_TXE:  vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_SPI_UNIT_0_RXF:  vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_SPI_UNIT_0_TXE:  vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_SERIAL_COMM_UNIT_1_TXE:  vec_class = vpit_pkg::VPIT_CL_PER;
         `VPIT_V_SERIAL_COMM_UNIT_1_TXI:  vec_class = vpit_pkg::VPIT_CL_PER;
         // Reserved and overlay slots never request
         default:           vec_class = vpit_pkg::VPIT_CL_NONE;
      endcase
   endfunction : vec_class

   // ----------------------------------------
   // Effective level
   // ----------------------------------------
   // Out-of-range settings clamp to the nearest legal level, not dropped
   function automatic logic [1:0] eff_level(
      input vpit_pkg::vpit_class_t c,
      input logic [1:0]            cfg
   );
      case (c)
         vpit_pkg::VPIT_CL_FIX3: eff_level = `VPIT_LVL3;
         vpit_pkg::VPIT_CL_FIX2: eff_level = `VPIT_LVL2;
         vpit_pkg::VPIT_CL_FIX1: eff_level = `VPIT_LVL1;
         vpit_pkg::VPIT_CL_FIX0: eff_level = `VPIT_LVL0;
         // [R5] Levels 1 to 3
         vpit_pkg::VPIT_CL_DBG:
            eff_level = (cfg == `VPIT_LVL0) ? `VPIT_LVL1 : cfg;
         // [R6] Levels 0 to 2
         vpit_pkg::VPIT_CL_PER:
            eff_level = (cfg == `VPIT_LVL3) ? `VPIT_LVL2 : cfg;
         default:                eff_level = `VPIT_LVL0;
      endcase
   endfunction : eff_level

   // ----------------------------------------
   // Vector address
   // ----------------------------------------
   // Entry holds a call with 19 target bits; full range is not reachable
   function automatic logic [`VPIT_ADDR_W-1:0] vec_addr(
      input logic [`VPIT_BASE_W-1:0] base,
      input logic [`VPIT_VEC_W-1:0]  v
   );
      logic [`VPIT_ADDR_W-1:0] b;
      logic [`VPIT_ADDR_W-1:0] o;
      b = {base, {`VPIT_BASE_SHIFT{1'b0}}};
      o = {{(`VPIT_ADDR_W - `VPIT_VEC_W){1'b0}}, v};
      // [R3] Base plus offset
      // [R13] Two words per entry
      vec_addr = b + (o << `VPIT_ENTRY_SHIFT);
   endfunction : vec_addr

   // ----------------------------------------
   // State
   // ----------------------------------------
   vpit_pkg::vpit_state_t s_reg;
   vpit_pkg::vpit_state_t s_next;

   logic [`VPIT_NVEC-1:0]   eligible;
   vpit_pkg::vpit_lvl_vec_t levels;
   logic                    win_valid;
   logic [`VPIT_VEC_W-1:0]  win_vector;
   logic [1:0]              win_level;
   logic                    ext_fall;
   logic                    ext_req;
   logic                    ack_ext;

   // ----------------------------------------
   // Eligibility
   // ----------------------------------------
   always_comb begin
      // Pin is active low; a fall is high then low through the flops
      ext_fall = ~s_reg.sync2 & s_reg.sync3;
      ext_req  = i_ext_edge_mode ? s_reg.ext_latch : ~s_reg.sync2;
      for (int i = 0; i < `VPIT_NVEC; i++) begin
         levels[i] = eff_level(vec_class(i[`VPIT_VEC_W-1:0]), i_src.level_cfg[i]);
         // [R15] Pending and enabled only
         eligible[i] = i_src.pending[i] & i_src.enable[i]
                     & (vec_class(i[`VPIT_VEC_W-1:0]) != vpit_pkg::VPIT_CL_NONE);
      end
      // [R6] Pin request replaces its slot
      eligible[`VPIT_V_EXT_A] = ext_req & i_src.enable[`VPIT_V_EXT_A];
   end

   vpit_arbiter #(
      .NVEC (`VPIT_NVEC)
   ) u_arb (
      .i_eligible (eligible),
      .i_levels   (levels),
      .o_valid    (win_valid),
      .o_vector   (win_vector),
      .o_level    (win_level)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      // Pin passes two flops before any reader
      s_next.sync1 = i_ext_request_a_n;
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;
      ack_ext = i_core.ack & (s_reg.st == vpit_pkg::VPIT_ST_SERVE)
              & (s_reg.grant.vector == `VPIT_V_EXT_A) & ~s_reg.grant.is_reset;
      // Set after clear so a new edge survives the acknowledge
      if (ack_ext || !i_ext_edge_mode) begin
         s_next.ext_latch = 1'b0;
      end
      if (ext_fall && i_ext_edge_mode) begin
         s_next.ext_latch = 1'b1;
      end
      // [R14] Overlay of reset addresses
      s_next.overlay = (i_vector_base == `VPIT_OVERLAY_BASE);
      case (s_reg.st)
         vpit_pkg::VPIT_ST_BOOT: begin
            // [R12] Boot or watchdog entry
            s_next.grant.valid    = 1'b1;
            s_next.grant.is_reset = 1'b1;
            s_next.grant.vector   = '0;
            s_next.grant.level    = `VPIT_LVL3;
            s_next.grant.addr     = i_wdog_reset_cause ? `VPIT_COP_ADDR
                                                       : `VPIT_BOOT_ADDR;
            if (i_core.ack && s_reg.grant.valid) begin
               s_next.grant.valid = 1'b0;
               s_next.st          = vpit_pkg::VPIT_ST_IDLE;
            end
         end
         vpit_pkg::VPIT_ST_IDLE: begin
            s_next.grant.valid    = 1'b0;
            s_next.grant.is_reset = 1'b0;
            // [R15] Winner at or above mask
            if (win_valid && win_level >= i_core.mask_level) begin
               s_next.grant.valid  = 1'b1;
               s_next.grant.vector = win_vector;
               s_next.grant.level  = win_level;
               // [R3] Fetch address formed
               s_next.grant.addr   = vec_addr(i_vector_base, win_vector);
               s_next.st           = vpit_pkg::VPIT_ST_SERVE;
            end
         end
         vpit_pkg::VPIT_ST_SERVE: begin
            // Held until taken; a later winner waits its turn
            if (i_core.ack) begin
               s_next.grant.valid = 1'b0;
               s_next.st          = vpit_pkg::VPIT_ST_IDLE;
            end
         end
         default: begin
            s_next.st          = vpit_pkg::VPIT_ST_IDLE;
            s_next.grant.valid = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         // Idle level of the pin, so no false edge follows reset
         s_reg.sync1     <= `VPIT_PIN_IDLE;
         s_reg.sync2     <= `VPIT_PIN_IDLE;
         s_reg.sync3     <= `VPIT_PIN_IDLE;
         s_reg.ext_latch <= 1'b0;
         s_reg.st        <= vpit_pkg::VPIT_ST_BOOT;
         s_reg.grant     <= '0;
         s_reg.overlay   <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_grant       = s_reg.grant;
   assign o_overlay     = s_reg.overlay;
   assign o_ext_pending = s_reg.ext_latch;

endmodule : vpit_top

// ---- rtl/vpit_defs.svh ----
/*
 Constants of the vectored priority interrupt table: widths, addresses,
 levels and vector numbers. Assumes inclusion by the package and top.
*/
`ifndef VPIT_DEFS_SVH
`define VPIT_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define VPIT_NVEC         64
`define VPIT_VEC_W        6
`define VPIT_ADDR_W       21
`define VPIT_BASE_W       13
`define VPIT_BASE_SHIFT   8
`define VPIT_ENTRY_SHIFT  1
`define VPIT_REACH_BITS   19

// ----------------------------------------
// Addresses and levels
// ----------------------------------------
`define VPIT_BOOT_ADDR    21'h02_0000
`define VPIT_COP_ADDR     21'h02_0002
`define VPIT_OVERLAY_BASE 13'h0200
`define VPIT_LVL0         2'h0
`define VPIT_LVL1         2'h1
`define VPIT_LVL2         2'h2
`define VPIT_LVL3         2'h3
`define VPIT_PIN_IDLE     1'b1

// ----------------------------------------
// Vector numbers
// ----------------------------------------
`define VPIT_V_ILLEGAL    6'h02
`define VPIT_V_SWI3       6'h03
`define VPIT_V_HWSTACK    6'h04
`define VPIT_V_MISALIGN   6'h05
`define VPIT_V_DBG_STEP   6'h06
`define VPIT_V_DBG_BKPT0  6'h07
`define VPIT_V_DBG_TRACE  6'h09
`define VPIT_V_DBG_TXE    6'h0A
`define VPIT_V_DBG_RXF    6'h0B
`define VPIT_V_SWI2       6'h0E
`define VPIT_V_SWI1       6'h0F
`define VPIT_V_SWI0       6'h10
`define VPIT_V_EXT_A      6'h11
`define VPIT_V_LVD        6'h14
`define VPIT_V_CLKGEN     6'h15
`define VPIT_V_FL_ACCERR  6'h16
`define VPIT_V_FL_CCIF    6'h17
`define VPIT_V_FL_CBEIF   6'h18
`define VPIT_V_CAN_BOFF   6'h1A
`define VPIT_V_CAN_ERR    6'h1B
`define VPIT_V_CAN_WAKE   6'h1C
`define VPIT_V_CAN_MB     6'h1D
`define VPIT_V_PORT_C     6'h21
`define VPIT_V_PORT_B     6'h22
`define VPIT_V_PORT_A     6'h23
`define VPIT_V_SPI_UNIT_1_RXF   6'h26
`define VPIT_V_SPI_UNIT_1_TXE   6'h27
`define VPIT_V_SPI_UNIT_0_RXF   6'h28
`define VPIT_V_SPI_UNIT_0_TXE   6'h29
`define VPIT_V_SERIAL_COMM_UNIT_1_TXE   6'h2A
`define VPIT_V_SERIAL_COMM_UNIT_1_TXI   6'h2B

`endif

// ---- rtl/vpit_pkg.sv ----
/*
 Types of the vectored priority interrupt table.
 Assumes vpit_defs.svh is on the include path.
*/
`include "vpit_defs.svh"

package vpit_pkg;

   typedef logic [`VPIT_NVEC-1:0][1:0] vpit_lvl_vec_t;

   typedef struct packed {
      logic [`VPIT_NVEC-1:0] pending;
      logic [`VPIT_NVEC-1:0] enable;
      vpit_lvl_vec_t         level_cfg;
   } vpit_src_t;

   typedef struct packed {
      logic [1:0] mask_level;
      logic       ack;
   } vpit_core_t;

   typedef struct packed {
      logic                    valid;
      logic                    is_reset;
      logic [`VPIT_VEC_W-1:0]  vector;
      logic [1:0]              level;
      logic [`VPIT_ADDR_W-1:0] addr;
   } vpit_grant_t;

   typedef enum logic [2:0] {
      VPIT_ST_BOOT  = 3'h1,
      VPIT_ST_IDLE  = 3'h2,
      VPIT_ST_SERVE = 3'h4
   } vpit_state_e_t;

   typedef enum logic [2:0] {
      VPIT_CL_NONE = 3'h0,
      VPIT_CL_FIX3 = 3'h1,
      VPIT_CL_FIX2 = 3'h2,
      VPIT_CL_FIX1 = 3'h3,
      VPIT_CL_FIX0 = 3'h4,
      VPIT_CL_DBG  = 3'h5,
      VPIT_CL_PER  = 3'h6
   } vpit_class_t;

   typedef struct packed {
      logic          sync1;
      logic          sync2;
      logic          sync3;
      logic          ext_latch;
      vpit_state_e_t st;
      vpit_grant_t   grant;
      logic          overlay;
   } vpit_state_t;

endpackage : vpit_pkg

// ---- rtl/vpit_arbiter.sv ----
/*
 Combinational winner search over all vectors.
 Assumes eligibility and levels already resolved by the caller.
*/
`timescale 1ns/10ps
`include "vpit_defs.svh"

module vpit_arbiter #(
   parameter int NVEC = `VPIT_NVEC
) (
   input  wire logic [NVEC-1:0]        i_eligible,
   input  wire vpit_pkg::vpit_lvl_vec_t i_levels,
   output logic                        o_valid,
   output logic [`VPIT_VEC_W-1:0]      o_vector,
   output logic [1:0]                  o_level
);

   // ----------------------------------------
   // Search
   // ----------------------------------------
   // Walks downward so an equal level at a lower vector replaces the holder
   always_comb begin
      o_valid  = 1'b0;
      o_vector = '0;
      o_level  = `VPIT_LVL0;
      for (int i = NVEC - 1; i >= 0; i--) begin
         // [R1] Higher level wins
         if (i_eligible[i] && (!o_valid || i_levels[i] > o_level)) begin
            o_valid  = 1'b1;
            o_vector = i[`VPIT_VEC_W-1:0];
            o_level  = i_levels[i];
         end
         // [R2] Tie to lowest vector
         else if (i_eligible[i] && i_levels[i] == o_level) begin
            o_vector = i[`VPIT_VEC_W-1:0];
         end
      end
   end

endmodule : vpit_arbiter

// ---- testbench/vpit_chk.sv ----
/*
 Assertions on the interrupt table's grant port and overlay flag.
 Assumes a bind to vpit_top; one clock, synchronous reset.
*/
`timescale 1ns/10ps
`include "vpit_defs.svh"

module vpit_chk (
   input wire logic                    i_clk,
   input wire logic                    i_rst,
   input wire vpit_pkg::vpit_src_t     i_src,
   input wire logic                    i_wdog_reset_cause,
   input wire logic [`VPIT_BASE_W-1:0] i_vector_base,
   input wire vpit_pkg::vpit_core_t    i_core,
   input wire vpit_pkg::vpit_grant_t   o_grant,
   input wire logic                    o_overlay
);
   // --------------------
   // Helpers
   // --------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic                  g;
   logic [5:0]            v;
   logic [`VPIT_NVEC-1:0] elig_q;
   assign g = o_grant.valid && !o_grant.is_reset;
   assign v = o_grant.vector;
   // Eligible set seen at the selecting edge
   always_ff @(posedge i_clk) elig_q <= i_src.pending & i_src.enable;
   sequence s_take; o_grant.valid && i_core.ack; endsequence
   sequence s_free; !o_grant.valid; endsequence
   // --------------------
   // Properties
   // --------------------
   property p_boot;
      $fell(i_rst) |=> o_grant.valid && o_grant.is_reset && o_grant.level == `VPIT_LVL3 &&
         o_grant.addr == ($past(i_wdog_reset_cause) ? `VPIT_COP_ADDR : `VPIT_BOOT_ADDR);
   endproperty
   property p_hold; o_grant.valid && !i_core.ack |=> $stable(o_grant); endproperty
   property p_take; s_take |=> s_free; endproperty
   // Base and mask are those of the selecting edge; the core may move them later
   property p_addr;
      $rose(o_grant.valid) && g |->
         o_grant.addr == {$past(i_vector_base), 8'h00} + {v, 1'b0};
   endproperty
   property p_fix; g && v inside {[2:5]} |-> o_grant.level == `VPIT_LVL3; endproperty
   property p_swi; g && v inside {[14:16]} |-> o_grant.level == 2'(16 - v); endproperty
   property p_dbg; g && v inside {6, 7, [9:11]} |-> o_grant.level != `VPIT_LVL0; endproperty
   property p_per;
      g && v > 16 |-> o_grant.level != `VPIT_LVL3 &&
         v inside {17, [20:24], [26:29], [33:35], [38:43]};
   endproperty
   property p_mask;
      $rose(o_grant.valid) && g |-> o_grant.level >= $past(i_core.mask_level);
   endproperty
   property p_elig; $rose(o_grant.valid) && g && v != 17 |-> elig_q[v]; endproperty
   property p_over;
      1'b1 |=> o_overlay == ($past(i_vector_base) == `VPIT_OVERLAY_BASE);
   endproperty
   a_boot: assert property (p_boot) else $error("reset entry wrong");
   a_hold: assert property (p_hold) else $error("grant moved before ack");
   a_take: assert property (p_take) else $error("grant kept after ack");
   a_addr: assert property (p_addr) else $error("fetch address wrong");
   a_fix: assert property (p_fix) else $error("core exception level");
   a_swi: assert property (p_swi) else $error("software level");
   a_dbg: assert property (p_dbg) else $error("debug level");
   a_per: assert property (p_per) else $error("peripheral vector or level");
   a_mask: assert property (p_mask) else $error("grant below mask");
   a_elig: assert property (p_elig) else $error("grant without request");
   a_over: assert property (p_over) else $error("overlay flag wrong");
endmodule : vpit_chk

bind vpit_top vpit_chk i_vpit_chk (.i_clk(i_clk), .i_rst(i_rst), .i_src(i_src),
   .i_wdog_reset_cause(i_wdog_reset_cause), .i_vector_base(i_vector_base),
   .i_core(i_core), .o_grant(o_grant), .o_overlay(o_overlay));

// ---- testbench/vpit_core_model.sv ----
/*
 Processor core model: holds a mask level and takes each grant.
 Assumes grants are registered on the same clock.
*/
`timescale 1ns/10ps

module vpit_core_model (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire vpit_pkg::vpit_grant_t i_grant,
   input  wire logic [1:0]            i_mask,
   input  wire logic [1:0]            i_delay,
   output vpit_pkg::vpit_core_t       o_core
);
   logic [1:0] cnt_reg;
   logic       ack_reg;
   assign o_core = '{mask_level: i_mask, ack: ack_reg};
   // One-cycle ack after a chosen wait; slow takes stretch the grant
   always @(posedge i_clk) begin
      if (i_rst || ack_reg || !i_grant.valid) begin
         ack_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else if (cnt_reg == i_delay) begin
         ack_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end
endmodule : vpit_core_model

// ---- testbench/tb.sv ----
/*
 Bench of the interrupt table: reset entry, vector sweep, pin, random.
 Assumes the core model takes every grant.
*/
`timescale 1ns/10ps
`include "vpit_defs.svh"

module tb;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic                    pin_n = 1'b1;
   logic                    edge_mode = 1'b0;
   logic                    wdog = 1'b0;
   logic [`VPIT_BASE_W-1:0] base = '0;
   logic [1:0]              mask = '0;
   logic [1:0]              delay = '0;
   vpit_pkg::vpit_src_t     src = '0;
   vpit_pkg::vpit_core_t    core;
   vpit_pkg::vpit_grant_t   grant;
   logic                    overlay;
   logic                    ext_pend;
   int                      failures = 0;
   int                      cmp_count = 0;
   int                      cyc = 0;
   integer                  seed = 32'h3060_56f2;

   vpit_top i_vpit_top (.i_clk(clk), .i_rst(rst), .i_src(src), .i_ext_request_a_n(pin_n),
      .i_ext_edge_mode(edge_mode), .i_wdog_reset_cause(wdog), .i_vector_base(base),
      .i_core(core), .o_grant(grant), .o_overlay(overlay), .o_ext_pending(ext_pend));
   vpit_core_model i_vpit_core_model (.i_clk(clk), .i_rst(rst), .i_grant(grant),
      .i_mask(mask), .i_delay(delay), .o_core(core));
   always #50 clk = ~clk;

   // --------------------
   // Model and checks
   // --------------------
   // level table
   function automatic int mlvl(int v, int c);
      if (v inside {[2:5]}) return 3;
      if (v inside {[14:16]}) return 16 - v;
      if (v inside {6, 7, [9:11]}) return (c == 0) ? 1 : c;
      if (v inside {17, [20:24], [26:29], [33:35], [38:43]}) return (c == 3) ? 2 : c;
      return -1;
   endfunction : mlvl

   // winner search over a queue of live requests
   function automatic int mwin(bit p17);
      int q[$];
      int b;
      b = -1;
      for (int v = 0; v < 44; v++) begin
         if (mlvl(v, src.level_cfg[v]) >= 0 && src.enable[v]
             && (v == 17 ? p17 : src.pending[v])) q.push_back(v);
      end
      // Queue is in ascending order, so a tie keeps the lower vector
      foreach (q[i]) begin
         if (b < 0 || mlvl(q[i], src.level_cfg[q[i]]) > mlvl(b, src.level_cfg[b])) b = q[i];
      end
      if (b >= 0 && mlvl(b, src.level_cfg[b]) < int'(mask)) b = -1;
      return b;
   endfunction : mwin

   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic wait_idle();
      int k;
      k = 0;
      while (grant.valid !== 1'b0 && k < 12) begin
         @(negedge clk);
         k++;
      end
      chk("idle", grant.valid, 0);
      @(posedge clk);
   endtask : wait_idle

   task automatic serve(string n, bit p17, logic [63:0] nxt);
      int w;
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (grant.valid !== 1'b1 && k < 8);
      w = mwin(p17);
      chk("valid", grant.valid, w >= 0);
      if (w >= 0) begin
         chk("vector", grant.vector, w);
         chk("level", grant.level, mlvl(w, src.level_cfg[w]));
         chk("addr", grant.addr, (int'(base) << 8) + 2 * w);
         chk("is_reset", grant.is_reset, 0);
         // Slots 0 and 1 hold jumps, so no interrupt may land there
         chk("call slot", grant.vector >= 2, 1);
         if (p17) chk("latch", ext_pend, edge_mode);
      end
      @(posedge clk);
      src.pending <= nxt;
      pin_n <= 1'b1;
      wait_idle();
      $display("test %s done", n);
   endtask : serve

   task automatic do_reset(bit wd, logic [`VPIT_BASE_W-1:0] b);
      @(posedge clk);
      rst <= 1'b1;
      wdog <= wd;
      base <= b;
      repeat (5) @(posedge clk);
      chk("quiet", 32'(grant), 0);
      rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("entry", {grant.valid, grant.is_reset, grant.level}, 4'hf);
      chk("entry addr", grant.addr, wd ? 32'h0002_0002 : 32'h0002_0000);
      chk("overlay", overlay, b == 13'h0200);
      if (b == 13'h0200) chk("overlay slot", grant.addr, (int'(b) << 8) + 2 * wd);
      wait_idle();
      $display("test reset done");
   endtask : do_reset

   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         close_out();
      end
   end

   // --------------------
   // Sequence
   // --------------------
   initial begin
      do_reset(1'b0, 13'h0123);
      do_reset(1'b1, 13'h0200);
      delay <= 2'h1;
      for (int v = 0; v < 44; v++) begin
         src.pending <= 64'h1 << v;
         src.enable <= '1;
         src.level_cfg <= {$random(seed), $random(seed), $random(seed), $random(seed)};
         serve("sweep", 1'b0, '0);
      end
      delay <= 2'h3;
      src.pending <= 64'h0001_0000;
      serve("hold", 1'b0, 64'h4);
      serve("after", 1'b0, '0);
      for (int m = 0; m < 2; m++) begin
         edge_mode <= m[0];
         pin_n <= 1'b0;
         serve("pin", 1'b1, '0);
         chk("latch clear", ext_pend, 0);
      end
      for (int i = 0; i < 80; i++) begin
         src.pending <= {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
         src.enable <= {$random(seed), $random(seed)};
         src.level_cfg <= {$random(seed), $random(seed), $random(seed), $random(seed)};
         mask <= 2'($random(seed));
         delay <= 2'($random(seed));
         base <= 13'($random(seed));
         serve("random", 1'b0, '0);
      end
      close_out();
   end
endmodule : tb
